// ---- tcl_pkg.sv ----
// tcl_pkg: constants, register map and carrier types for the control-law core.
// assumes a single 100 MHz clock and an AXI4-Lite master holding one access at a time.
package tcl_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_SP     = 8'h08;
    localparam logic [7:0] ADDR_PV     = 8'h0C;
    localparam logic [7:0] ADDR_HYS    = 8'h10;
    localparam logic [7:0] ADDR_DEAD   = 8'h14;
    localparam logic [7:0] ADDR_PBAND  = 8'h18;
    localparam logic [7:0] ADDR_ITIME  = 8'h1C;
    localparam logic [7:0] ADDR_DTIME  = 8'h20;
    localparam logic [7:0] ADDR_ALPHA  = 8'h24;
    localparam logic [7:0] ADDR_STATUS = 8'h28;
    localparam logic [7:0] ADDR_MV     = 8'h2C;
    // control register bits
    localparam int CTRL_RUN     = 0;
    localparam int CTRL_SWRESET = 1;
    localparam int CTRL_PBX10   = 2;
    // config register bits
    localparam int CFG_METHOD = 0;
    localparam int CFG_MODE   = 1;
    localparam int CFG_DIRECT = 2;
    localparam int CFG_DP_LO  = 4;
    // reset values and write limits, tenths of a unit unless noted
    localparam logic [15:0] HYS_DEFAULT   = 16'h000A;
    localparam logic [15:0] HYS_MIN       = 16'h0001;
    localparam logic [15:0] HYS_MAX       = 16'h270F;
    localparam logic [15:0] DEAD_DEFAULT  = 16'h0000;
    localparam logic signed [15:0] DEAD_MIN = -16'sd1999;
    localparam logic signed [15:0] DEAD_MAX = 16'sd9999;
    localparam logic [15:0] PBAND_DEFAULT = 16'h0050;
    localparam logic [15:0] PBAND_MIN     = 16'h0001;
    localparam logic [15:0] PBAND_MAX     = 16'h270F;
    localparam logic [15:0] ITIME_DEFAULT = 16'h00E9; // whole seconds
    localparam logic [15:0] ITIME_MAX     = 16'h0F9F;
    localparam logic [15:0] DTIME_DEFAULT = 16'h0190;
    localparam logic [15:0] DTIME_MAX     = 16'h270F;
    localparam logic [7:0]  ALPHA_DEFAULT = 8'h41;    // hundredths
    localparam logic [7:0]  ALPHA_MAX     = 8'h64;
    // manipulated variable in tenths of a percent
    localparam logic [15:0] MV_FULL = 16'h03E8;
    localparam logic [15:0] MV_ZERO = 16'h0000;
    // control update period and bus response codes
    localparam int SAMPLE_NS     = 100000;
    localparam int CLK_NS        = 10;
    localparam int SAMPLE_CYCLES = SAMPLE_NS / CLK_NS;
    localparam int SAMPLES_PER_S = 10000;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [0:0] {METHOD_PID = 1'b0, METHOD_ONOFF = 1'b1} tcl_method_t;

    typedef struct packed {
        logic        method;
        logic        heat_cool;
        logic        direct;
        logic [1:0]  dec_point;
    } tcl_cfg_t;

    typedef struct packed {
        logic [15:0] heat;
        logic [15:0] cool;
    } tcl_mv_t;
endpackage

// ---- tcl_core.sv ----
// tcl_core: per-channel control law with AXI4-Lite registers.
// assumes process_value is a signed tenth-unit word from another clock domain.
//
// Local design decisions: the address map and register access over AXI4-Lite.
module tcl_core (
    // clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // axi4-lite write address
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    // axi4-lite write response
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // sensor and actuators
    input  wire logic signed [15:0] process_value,
    output logic [15:0]             heat_mv,
    output logic [15:0]             cool_mv
);
    logic signed [15:0] pv_meta_reg;
    logic signed [15:0] pv_reg;
    logic               run_reg;
    logic               pbx10_req_reg;
    logic               pbx10_reg;
    tcl_pkg::tcl_cfg_t  cfg_reg;
    logic signed [15:0] sp_reg;
    logic [15:0]        hys_heat_reg;
    logic [15:0]        hys_cool_reg;
    logic signed [15:0] dead_reg;
    logic [15:0]        pband_reg;
    logic [15:0]        itime_reg;
    logic [15:0]        dtime_reg;
    logic [7:0]         alpha_reg;
    logic               refused_reg;
    tcl_pkg::tcl_mv_t   mv_reg;
    logic               heat_on_reg;
    logic               cool_on_reg;
    logic [31:0]        tick_cnt_reg;
    logic signed [47:0] integ_reg;
    logic signed [15:0] pv_prev_reg;
    logic [7:0]         aw_addr_reg;
    logic               aw_full_reg;
    logic [31:0]        w_data_reg;
    logic [3:0]         w_strb_reg;
    logic               w_full_reg;
    logic               tick;

    // two flops: the sensor word comes from outside this clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pv_meta_reg <= '0;
            pv_reg      <= '0;
        end else begin
            pv_meta_reg <= process_value;
            pv_reg      <= pv_meta_reg;
        end
    end

    // write channel capture, address and data in either order
    wire do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready  = !w_full_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (s_axi_wvalid && !w_full_reg) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end
    end

    // byte-lane merge of the low half word
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    wire [15:0] wr16     = merge16(16'h0000, w_data_reg, w_strb_reg);
    wire        wr_known = (aw_addr_reg[1:0] == 2'h0) && (aw_addr_reg <= tcl_pkg::ADDR_MV);
    // out-of-range values are refused with slverr and leave the register alone
    logic       wr_ok;
    always_comb begin
        wr_ok = 1'b1;
        unique case (aw_addr_reg)
            tcl_pkg::ADDR_CONFIG: wr_ok = !run_reg;
            tcl_pkg::ADDR_HYS:    wr_ok = (wr16 >= tcl_pkg::HYS_MIN) && (wr16 <= tcl_pkg::HYS_MAX)
                                       && (w_data_reg[31:16] >= tcl_pkg::HYS_MIN)
                                       && (w_data_reg[31:16] <= tcl_pkg::HYS_MAX);
            tcl_pkg::ADDR_DEAD:   wr_ok = ($signed(wr16) >= tcl_pkg::DEAD_MIN)
                                       && ($signed(wr16) <= tcl_pkg::DEAD_MAX);
            tcl_pkg::ADDR_PBAND:  wr_ok = (wr16 >= tcl_pkg::PBAND_MIN) && (wr16 <= tcl_pkg::PBAND_MAX);
            tcl_pkg::ADDR_ITIME:  wr_ok = wr16 <= tcl_pkg::ITIME_MAX;
            tcl_pkg::ADDR_DTIME:  wr_ok = wr16 <= tcl_pkg::DTIME_MAX;
            tcl_pkg::ADDR_ALPHA:  wr_ok = wr16[7:0] <= tcl_pkg::ALPHA_MAX && wr16[15:8] == 8'h00;
            default:              wr_ok = 1'b1;
        endcase
    end
    wire wr_en = do_write && wr_known && wr_ok;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= tcl_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= !wr_known ? tcl_pkg::RESP_DECERR :
                            (wr_ok ? tcl_pkg::RESP_OKAY : tcl_pkg::RESP_SLVERR);
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // run flag and pending x10 option
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_reg       <= 1'b0;
            pbx10_req_reg <= 1'b0;
        end else if (wr_en && aw_addr_reg == tcl_pkg::ADDR_CTRL) begin
            if (w_strb_reg[0]) begin
                run_reg       <= w_data_reg[tcl_pkg::CTRL_RUN];
                pbx10_req_reg <= w_data_reg[tcl_pkg::CTRL_PBX10];
            end
        end
    end

    // the x10 option only acts on a control write that also sets the software reset bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pbx10_reg <= 1'b0;
        end else if (wr_en && aw_addr_reg == tcl_pkg::ADDR_CTRL && w_strb_reg[0]
                     && w_data_reg[tcl_pkg::CTRL_SWRESET]) begin
            pbx10_reg <= w_data_reg[tcl_pkg::CTRL_PBX10];
        end
    end

    // configuration, held while running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg <= '{method: tcl_pkg::METHOD_PID, heat_cool: 1'b0, direct: 1'b0,
                         dec_point: 2'h0};
        end else if (wr_en && aw_addr_reg == tcl_pkg::ADDR_CONFIG && w_strb_reg[0]) begin
            cfg_reg.method    <= w_data_reg[tcl_pkg::CFG_METHOD];
            cfg_reg.heat_cool <= w_data_reg[tcl_pkg::CFG_MODE];
            cfg_reg.direct    <= w_data_reg[tcl_pkg::CFG_DIRECT];
            cfg_reg.dec_point <= w_data_reg[tcl_pkg::CFG_DP_LO +: 2];
        end
    end

    // tuning parameters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp_reg       <= '0;
            hys_heat_reg <= tcl_pkg::HYS_DEFAULT;
            hys_cool_reg <= tcl_pkg::HYS_DEFAULT;
            dead_reg     <= tcl_pkg::DEAD_DEFAULT;
            pband_reg    <= tcl_pkg::PBAND_DEFAULT;
            itime_reg    <= tcl_pkg::ITIME_DEFAULT;
            dtime_reg    <= tcl_pkg::DTIME_DEFAULT;
            alpha_reg    <= tcl_pkg::ALPHA_DEFAULT;
        end else if (wr_en) begin
            unique case (aw_addr_reg)
                tcl_pkg::ADDR_SP:    sp_reg    <= merge16(sp_reg, w_data_reg, w_strb_reg);
                tcl_pkg::ADDR_HYS: begin
                    hys_heat_reg <= wr16;
                    hys_cool_reg <= w_data_reg[31:16];
                end
                tcl_pkg::ADDR_DEAD:  dead_reg  <= wr16;
                tcl_pkg::ADDR_PBAND: pband_reg <= wr16;
                tcl_pkg::ADDR_ITIME: itime_reg <= wr16;
                tcl_pkg::ADDR_DTIME: dtime_reg <= wr16;
                tcl_pkg::ADDR_ALPHA: alpha_reg <= wr16[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refused_reg <= 1'b0;
        end else if (do_write && wr_known && !wr_ok) begin
            refused_reg <= 1'b1;
        end else if (do_write && aw_addr_reg == tcl_pkg::ADDR_STATUS) begin
            refused_reg <= 1'b0;
        end
    end

    // read channel, one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= tcl_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= tcl_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                tcl_pkg::ADDR_CTRL:   s_axi_rdata <= {29'h0, pbx10_req_reg, 1'b0, run_reg};
                tcl_pkg::ADDR_CONFIG: s_axi_rdata <= {26'h0, cfg_reg.dec_point, 1'b0,
                                                      cfg_reg.direct, cfg_reg.heat_cool,
                                                      cfg_reg.method};
                tcl_pkg::ADDR_SP:     s_axi_rdata <= {{16{sp_reg[15]}}, sp_reg};
                tcl_pkg::ADDR_PV:     s_axi_rdata <= {{16{pv_reg[15]}}, pv_reg};
                tcl_pkg::ADDR_HYS:    s_axi_rdata <= {hys_cool_reg, hys_heat_reg};
                tcl_pkg::ADDR_DEAD:   s_axi_rdata <= {{16{dead_reg[15]}}, dead_reg};
                tcl_pkg::ADDR_PBAND:  s_axi_rdata <= {16'h0, pband_reg};
                tcl_pkg::ADDR_ITIME:  s_axi_rdata <= {16'h0, itime_reg};
                tcl_pkg::ADDR_DTIME:  s_axi_rdata <= {16'h0, dtime_reg};
                tcl_pkg::ADDR_ALPHA:  s_axi_rdata <= {24'h0, alpha_reg};
                tcl_pkg::ADDR_STATUS: s_axi_rdata <= {28'h0, refused_reg, pbx10_reg,
                                                      cool_on_reg, heat_on_reg};
                tcl_pkg::ADDR_MV:     s_axi_rdata <= {mv_reg.cool, mv_reg.heat};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= tcl_pkg::RESP_DECERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // control update tick
    assign tick = (tick_cnt_reg == 32'(tcl_pkg::SAMPLE_CYCLES - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
    end

    // signed deviation oriented so positive means "needs heating"
    wire signed [17:0] err_raw = 18'(sp_reg) - 18'(pv_reg);
    wire signed [17:0] dev     = cfg_reg.direct ? -err_raw : err_raw;
    wire signed [17:0] half_db = 18'($signed(dead_reg) >>> 1);
    // cooling hysteresis only used in heat/cool mode
    wire [15:0]        hys_c   = cfg_reg.heat_cool ? hys_cool_reg : hys_heat_reg;

    // on/off decision, off at set point, back on after hysteresis
    // the outputs take the decision of the same update, not the one before it
    logic heat_on_next;
    logic cool_on_next;
    always_comb begin
        heat_on_next = heat_on_reg;
        cool_on_next = cool_on_reg;
        if (dev - half_db <= 18'sh0) begin
            heat_on_next = 1'b0;
        end else if (dev - half_db >= $signed(18'(hys_heat_reg))) begin
            heat_on_next = 1'b1;
        end
        if (!cfg_reg.heat_cool || -dev - half_db <= 18'sh0) begin
            cool_on_next = 1'b0;
        end else if (-dev - half_db >= $signed(18'(hys_c))) begin
            cool_on_next = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !run_reg) begin
            heat_on_reg <= 1'b0;
            cool_on_reg <= 1'b0;
        end else if (tick) begin
            heat_on_reg <= heat_on_next;
            cool_on_reg <= cool_on_next;
        end
    end

    // pid terms; band widens tenfold when enabled
    wire [19:0] pb_eff = pbx10_reg ? 20'(pband_reg) * 20'hA : 20'(pband_reg);
    // every operand signed, so a negative deviation stays negative
    wire signed [31:0] p_term = 32'(dev) * $signed(32'(tcl_pkg::MV_FULL))
                                / $signed({12'h0, pb_eff});
    wire signed [31:0] i_term = (itime_reg == 16'h0) ? 32'sh0 :
        32'(integ_reg / ($signed({32'h0, itime_reg}) * 48'(tcl_pkg::SAMPLES_PER_S)));
    // derivative on the measured value, weighted by the slope per second
    wire signed [31:0] slope  = 32'(pv_prev_reg) - 32'(pv_reg);
    wire signed [31:0] d_term = (cfg_reg.direct ? -slope : slope) * $signed(32'(dtime_reg))
                                * 32'(tcl_pkg::SAMPLES_PER_S) / 32'sd100000;
    // set-point weighting by alpha on the proportional part
    wire signed [31:0] pid_sum = (p_term * $signed(32'(alpha_reg)))
                                 / $signed(32'(tcl_pkg::ALPHA_MAX))
                                 + i_term + d_term;

    always_ff @(posedge aclk) begin
        if (!aresetn || !run_reg || cfg_reg.method == tcl_pkg::METHOD_ONOFF) begin
            integ_reg   <= '0;
            pv_prev_reg <= pv_reg;
        end else if (tick) begin
            integ_reg   <= integ_reg + 48'(dev) * $signed(48'(tcl_pkg::MV_FULL))
                           / $signed({28'h0, pb_eff});
            pv_prev_reg <= pv_reg;
        end
    end

    // limit to 0..100 percent
    function automatic logic [15:0] clamp_mv(input logic signed [31:0] v);
        if (v <= 32'sh0) clamp_mv = tcl_pkg::MV_ZERO;
        else if (v >= $signed(32'(tcl_pkg::MV_FULL))) clamp_mv = tcl_pkg::MV_FULL;
        else clamp_mv = v[15:0];
    endfunction

    // dead band shifts each side; negative band overlaps them
    wire signed [31:0] db_shift = 32'(half_db) * $signed(32'(tcl_pkg::MV_FULL))
                                  / $signed({12'h0, pb_eff});

    always_ff @(posedge aclk) begin
        if (!aresetn || !run_reg) begin
            mv_reg <= '0;
        end else if (tick) begin
            if (cfg_reg.method == tcl_pkg::METHOD_ONOFF) begin
                mv_reg.heat <= heat_on_next ? tcl_pkg::MV_FULL : tcl_pkg::MV_ZERO;
                mv_reg.cool <= cool_on_next ? tcl_pkg::MV_FULL : tcl_pkg::MV_ZERO;
            end else if (cfg_reg.heat_cool) begin
                mv_reg.heat <= clamp_mv(pid_sum - db_shift);
                mv_reg.cool <= clamp_mv(-pid_sum - db_shift);
            end else begin
                mv_reg.heat <= clamp_mv(pid_sum);
                mv_reg.cool <= tcl_pkg::MV_ZERO;
            end
        end
    end

    assign heat_mv = mv_reg.heat;
    assign cool_mv = mv_reg.cool;
endmodule

// ---- tcl_core_chk.sv ----
// tcl_core_chk: port-level assertions for the control-law core.
// assumes it is bound to every tcl_core instance and sees only its ports.
module tcl_core_chk (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // actuators
    input wire logic [15:0] heat_mv,
    input wire logic [15:0] cool_mv
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_bresp_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was taken");
    chk_rdata_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before it was taken");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read address taken but no pending answer followed");
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write got no response");
    chk_unmapped_read: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr > tcl_pkg::ADDR_MV
        |=> s_axi_rvalid && s_axi_rresp == tcl_pkg::RESP_DECERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not decoded as error");
    chk_heat_range: assert property (
        heat_mv <= tcl_pkg::MV_FULL)
        else $error("heating output above full scale");
    chk_cool_range: assert property (
        cool_mv <= tcl_pkg::MV_FULL)
        else $error("cooling output above full scale");
    chk_mv_settles: assert property (
        $changed(heat_mv) |=> $stable(heat_mv)[*8])
        else $error("heating output chatters");
    chk_reset_quiet: assert property (
        $rose(aresetn) |-> heat_mv == 16'h0 && cool_mv == 16'h0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not quiet after reset");
endmodule
bind tcl_core tcl_core_chk i_tcl_core_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .heat_mv(heat_mv),
    .cool_mv(cool_mv));

// ---- tcl_plant.sv ----
// tcl_plant: behavioural thermal load feeding the sensor word.
// assumes the bench loads a start temperature and the core drives the actuators.
module tcl_plant (
    // clock
    input  wire logic               aclk,
    // bench control
    input  wire logic signed [15:0] pv_in,
    input  wire logic               pv_load,
    // actuators and sensor
    input  wire logic [15:0]        heat_mv,
    input  wire logic [15:0]        cool_mv,
    output logic signed [15:0]      process_value
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0]        tick_reg = 12'h000;
    logic signed [15:0] pv_reg   = 16'sh0000;
    assign process_value = pv_reg;
    // slow drift so a held output moves the load, but stays inside any hysteresis used
    always @(posedge aclk) begin
        tick_reg <= tick_reg + 12'h001;
        if (pv_load)
            pv_reg <= pv_in;
        else if (tick_reg == 12'hFFF)
            pv_reg <= pv_reg + 16'(heat_mv != 16'h0) - 16'(cool_mv != 16'h0);
    end
endmodule

// ---- tb.sv ----
// tb: self-checking bench for tcl_core over AXI4-Lite with a thermal load.
// assumes a 100 MHz clock and the register map of tcl_pkg.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic               aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]        wdata = 32'h0, rdata;
    logic [3:0]         wstrb = 4'h0;
    logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic               arvalid = 1'b0, rready = 1'b0, pv_load = 1'b0;
    logic               awready, wready, bvalid, arready, rvalid;
    logic [1:0]         bresp, rresp;
    logic signed [15:0] pv_in = 16'sh0000, process_value;
    logic [15:0]        heat_mv, cool_mv;
    logic [33:0]        rq[$];
    logic [1:0]         bq[$];
    int                 n_fail = 0, samples_checked = 0, seed = 16;
    always #5 aclk = ~aclk;
    tcl_core i_tcl_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .process_value(process_value), .heat_mv(heat_mv),
        .cool_mv(cool_mv));
    tcl_plant i_tcl_plant (.aclk(aclk), .pv_in(pv_in), .pv_load(pv_load),
        .heat_mv(heat_mv), .cool_mv(cool_mv), .process_value(process_value));
    task automatic chk(input string what, input logic [33:0] e, input logic [33:0] s);
        samples_checked++;
        if (e !== s) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, e, s);
        end
    endtask
    // the monitor pairs every answer with the oldest note the driver left
    always @(posedge aclk) begin
        if (rvalid && rready)
            chk("read", rq.pop_front(), {rresp, rdata});
        if (bvalid && bready)
            chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask
    // load a temperature, then wait past one full control update
    task automatic settle(input logic signed [15:0] v);
        @(posedge aclk);
        pv_in <= v;
        pv_load <= 1'b1;
        @(posedge aclk);
        pv_load <= 1'b0;
        repeat (10010) @(posedge aclk);
    endtask
    task conclude;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    localparam logic [1:0]  OK = tcl_pkg::RESP_OKAY;
    localparam logic [1:0]  SE = tcl_pkg::RESP_SLVERR;
    localparam logic [31:0] ON = {16'h0, tcl_pkg::MV_FULL};
    logic [7:0]  ra [0:8] = '{tcl_pkg::ADDR_CTRL, tcl_pkg::ADDR_CONFIG, tcl_pkg::ADDR_HYS,
        tcl_pkg::ADDR_DEAD, tcl_pkg::ADDR_PBAND, tcl_pkg::ADDR_ITIME, tcl_pkg::ADDR_DTIME,
        tcl_pkg::ADDR_ALPHA, tcl_pkg::ADDR_MV};
    logic [31:0] rv [0:8] = '{32'h0, 32'h0, {tcl_pkg::HYS_DEFAULT, tcl_pkg::HYS_DEFAULT},
        32'h0, {16'h0, tcl_pkg::PBAND_DEFAULT}, {16'h0, tcl_pkg::ITIME_DEFAULT},
        {16'h0, tcl_pkg::DTIME_DEFAULT}, {24'h0, tcl_pkg::ALPHA_DEFAULT}, 32'h0};
    initial begin
        #950000;
        n_fail++;
        conclude;
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 9; i++) rd(ra[i], rv[i], OK);
        rd(8'h30, 32'h0, tcl_pkg::RESP_DECERR);
        wr(tcl_pkg::ADDR_HYS, 32'h000A0000, SE);
        wr(tcl_pkg::ADDR_ALPHA, 32'h00000065, SE);
        wr(tcl_pkg::ADDR_DEAD, 32'hFFFFF830, SE);
        rd(tcl_pkg::ADDR_STATUS, 32'h8, OK);
        wr(tcl_pkg::ADDR_STATUS, 32'h0, OK);
        rd(tcl_pkg::ADDR_HYS, {tcl_pkg::HYS_DEFAULT, tcl_pkg::HYS_DEFAULT}, OK);
        // on/off reverse then direct, cooling band wider so a wrong band choice shows
        wr(tcl_pkg::ADDR_CONFIG, 32'h1, OK);
        wr(tcl_pkg::ADDR_SP, 32'h64, OK);
        wr(tcl_pkg::ADDR_HYS, 32'h001E000A, OK);
        wr(tcl_pkg::ADDR_CTRL, 32'h1, OK);
        wr(tcl_pkg::ADDR_CONFIG, 32'h0, SE);
        rd(tcl_pkg::ADDR_CONFIG, 32'h1, OK);
        settle(16'(16'sd50 + ($random(seed) & 15)));
        rd(tcl_pkg::ADDR_MV, ON, OK);
        settle(16'sd100);
        rd(tcl_pkg::ADDR_MV, 32'h0, OK);
        settle(16'sd95);
        rd(tcl_pkg::ADDR_MV, 32'h0, OK);
        settle(16'sd85);
        rd(tcl_pkg::ADDR_MV, ON, OK);
        wr(tcl_pkg::ADDR_CTRL, 32'h0, OK);
        rd(tcl_pkg::ADDR_MV, 32'h0, OK);
        wr(tcl_pkg::ADDR_CONFIG, 32'h5, OK);
        wr(tcl_pkg::ADDR_CTRL, 32'h1, OK);
        settle(16'sd120);
        rd(tcl_pkg::ADDR_MV, ON, OK);
        settle(16'sd80);
        rd(tcl_pkg::ADDR_MV, 32'h0, OK);
        // pid with heat/cool split, far below set point: heating saturates, cooling idle
        wr(tcl_pkg::ADDR_CTRL, 32'h0, OK);
        wr(tcl_pkg::ADDR_CONFIG, 32'h2, OK);
        wr(tcl_pkg::ADDR_CTRL, 32'h1, OK);
        settle(-16'sd1000);
        rd(tcl_pkg::ADDR_MV, ON, OK);
        // refused bit still set by the config write refused while running
        wr(tcl_pkg::ADDR_CTRL, 32'h4, OK);
        rd(tcl_pkg::ADDR_STATUS, 32'h8, OK);
        wr(tcl_pkg::ADDR_CTRL, 32'h6, OK);
        rd(tcl_pkg::ADDR_STATUS, 32'hC, OK);
        repeat (4) @(posedge aclk);
        conclude;
    end
endmodule
